// ===== inc/fet_pkg.sv
// package: register map, field layout and types of the flash ecc test and suspend-mode block
package fet_pkg;
  localparam logic [11:0] OFS_SUSPEND_SEL = 12'h0E0;
  localparam logic [11:0] OFS_ENC_MON = 12'h100;
  localparam logic [11:0] OFS_TEST_CTRL = 12'h104;
  localparam logic [11:0] OFS_INIT = 12'h110;
  localparam int BIT_SUSP_MODE = 0;
  localparam int BIT_INIT = 0;
  localparam int BIT_PARITY = 10;
  localparam int BIT_CODE_VE = 5;
  localparam int BIT_DATA_VE = 4;
  localparam int BIT_ENC_DIS = 0;
  localparam int KEY_LSB = 8;
  localparam logic [7:0] TEST_KEY = 8'hA6;
  localparam logic [15:0] SUSPEND_SEL_RST = 16'h0000;
  localparam logic [15:0] ENC_MON_RST = 16'hFFFF;
  localparam logic [15:0] TEST_CTRL_RST = 16'h0030;
  localparam logic [2:0] DATA_ECC_PAD = 3'h7;

  typedef struct packed {
    logic code_verify_ecc_enable;
    logic data_verify_ecc_enable;
    logic encoder_disable_bit;
  } fet_test_t;

  typedef struct packed {
    logic parity;
    logic [9:0] ecc;
  } fet_code_t;
endpackage

// ===== hw/fet_ctrl.sv
// flash ecc test, encoder monitor and erase suspend mode control with apb slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module fet_ctrl (
  input wire logic CORE_CLK, // 20 MHz clock
  input wire logic NRST, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [11:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic [3:0] PSTRB, // apb byte strobes
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic DATA_FLASH_MODE, // 1 data flash mode, 0 code flash mode
  input wire fet_pkg::fet_code_t GEN_CODE, // code flash parity and ecc
  input wire logic [6:0] GEN_DATA_ECC, // data flash ecc
  input wire logic [15:0] DUMMY_ECC, // dummy ecc register value
  output logic ERASE_PRIORITY, // suspend mode bit
  output fet_pkg::fet_test_t TEST_CTRL, // verify and bypass controls
  output logic [15:0] WRITE_CHECK // parity/ecc written to flash
);
  logic susp_reg;
  fet_pkg::fet_test_t test_reg;
  logic [15:0] mon_reg;
  logic [15:0] mon_next;
  logic [15:0] wcheck_next;
  logic [31:0] rd_next;
  logic err_next;
  logic setup;
  logic wr_ok;
  logic init_req;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, fet_pkg::OFS_SUSPEND_SEL) || hit(a, fet_pkg::OFS_ENC_MON) || hit(a, fet_pkg::OFS_TEST_CTRL)
             || hit(a, fet_pkg::OFS_INIT);
  endfunction

  assign setup = PSEL && !PENABLE;
  // 16-bit registers need both low byte lanes
  assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && (PSTRB[1:0] == 2'h3);
  assign init_req = wr_ok && hit(PADDR, fet_pkg::OFS_INIT) && PWDATA[fet_pkg::BIT_INIT];

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      susp_reg <= fet_pkg::SUSPEND_SEL_RST[fet_pkg::BIT_SUSP_MODE];
    end else if (init_req) begin
      susp_reg <= fet_pkg::SUSPEND_SEL_RST[fet_pkg::BIT_SUSP_MODE];
    end else if (wr_ok && hit(PADDR, fet_pkg::OFS_SUSPEND_SEL)) begin
      susp_reg <= PWDATA[fet_pkg::BIT_SUSP_MODE];
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      test_reg <= '{fet_pkg::TEST_CTRL_RST[fet_pkg::BIT_CODE_VE], fet_pkg::TEST_CTRL_RST[fet_pkg::BIT_DATA_VE],
                    fet_pkg::TEST_CTRL_RST[fet_pkg::BIT_ENC_DIS]};
    end else if (wr_ok && hit(PADDR, fet_pkg::OFS_TEST_CTRL) && PSTRB[1]
                 && PWDATA[15:fet_pkg::KEY_LSB] == fet_pkg::TEST_KEY) begin
      test_reg <= '{PWDATA[fet_pkg::BIT_CODE_VE], PWDATA[fet_pkg::BIT_DATA_VE], PWDATA[fet_pkg::BIT_ENC_DIS]};
    end
  end

  always_comb begin
    mon_next = 16'h0000;
    if (DATA_FLASH_MODE) begin
      mon_next[fet_pkg::BIT_PARITY] = 1'b1;
      mon_next[9:0] = {fet_pkg::DATA_ECC_PAD, GEN_DATA_ECC};
    end else begin
      mon_next[fet_pkg::BIT_PARITY] = GEN_CODE.parity;
      mon_next[9:0] = GEN_CODE.ecc;
    end
  end

  always_comb begin
    wcheck_next = 16'h0000;
    if (test_reg.encoder_disable_bit) begin
      if (DATA_FLASH_MODE) begin
        wcheck_next[9:0] = {fet_pkg::DATA_ECC_PAD, DUMMY_ECC[6:0]};
        wcheck_next[fet_pkg::BIT_PARITY] = 1'b1;
      end else begin
        wcheck_next[10:0] = DUMMY_ECC[10:0];
      end
    end else begin
      wcheck_next = mon_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      mon_reg <= fet_pkg::ENC_MON_RST;
      WRITE_CHECK <= fet_pkg::ENC_MON_RST;
    end else begin
      mon_reg <= mon_next;
      WRITE_CHECK <= wcheck_next;
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    if (hit(PADDR, fet_pkg::OFS_SUSPEND_SEL)) begin
      rd_next[fet_pkg::BIT_SUSP_MODE] = susp_reg;
    end else if (hit(PADDR, fet_pkg::OFS_ENC_MON)) begin
      rd_next[15:0] = mon_reg;
      err_next = PWRITE;
    end else if (hit(PADDR, fet_pkg::OFS_TEST_CTRL)) begin
      rd_next[fet_pkg::BIT_CODE_VE] = test_reg.code_verify_ecc_enable;
      rd_next[fet_pkg::BIT_DATA_VE] = test_reg.data_verify_ecc_enable;
      rd_next[fet_pkg::BIT_ENC_DIS] = test_reg.encoder_disable_bit;
    end else if (!hit(PADDR, fet_pkg::OFS_INIT)) begin
      err_next = 1'b1;
    end
  end

  // answer one cycle after setup: access phase lasts one cycle
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PRDATA <= (setup && !PWRITE) ? rd_next : 32'h0000_0000;
      PSLVERR <= setup && err_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ERASE_PRIORITY <= 1'b0;
      TEST_CTRL <= '{fet_pkg::TEST_CTRL_RST[fet_pkg::BIT_CODE_VE], fet_pkg::TEST_CTRL_RST[fet_pkg::BIT_DATA_VE],
                     fet_pkg::TEST_CTRL_RST[fet_pkg::BIT_ENC_DIS]};
    end else begin
      ERASE_PRIORITY <= susp_reg;
      TEST_CTRL <= test_reg;
    end
  end

  a_key_gate_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_ok && hit(PADDR, fet_pkg::OFS_TEST_CTRL) && PWDATA[15:8] != fet_pkg::TEST_KEY) |=> $stable(test_reg))
    else $error("test control changed without key");
  a_key_reads_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (setup && !PWRITE && hit(PADDR, fet_pkg::OFS_TEST_CTRL)) |=> PRDATA[15:8] == 8'h00)
    else $error("key field read nonzero");
  a_init_clears_mode: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    init_req |=> !susp_reg ##1 !ERASE_PRIORITY)
    else $error("init did not clear suspend mode");
  a_data_parity_one: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    DATA_FLASH_MODE |=> mon_reg[10:7] == 4'hF)
    else $error("data mode monitor pad not one");
  a_code_mon_live: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !DATA_FLASH_MODE |=> mon_reg[10:0] == $past(GEN_CODE))
    else $error("code mode monitor wrong");
  a_data_ecc_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    DATA_FLASH_MODE |=> mon_reg[6:0] == $past(GEN_DATA_ECC))
    else $error("data ecc monitor wrong");
  a_mon_read_only: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (setup && PWRITE && hit(PADDR, fet_pkg::OFS_ENC_MON)) |=> PSLVERR && PREADY)
    else $error("monitor write not refused");
  a_bypass_dummy: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (test_reg.encoder_disable_bit && !DATA_FLASH_MODE) |=> WRITE_CHECK[10:0] == $past(DUMMY_ECC[10:0]))
    else $error("bypass did not use dummy value");
  a_suspend_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    (wr_ok && hit(PADDR, fet_pkg::OFS_SUSPEND_SEL)) |=> ##1 ERASE_PRIORITY == $past(PWDATA[0], 2))
    else $error("suspend mode not stored");

  a_ready_after_setup: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    setup
    |=> PREADY)
    else $error("no ready after setup");

  a_ready_single: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    PREADY
    |=> !PREADY)
    else $error("ready held too long");

  a_ready_in_access: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    PREADY
    |-> (PSEL && PENABLE))
    else $error("ready outside access phase");

  a_error_with_ready: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    PSLVERR
    |-> PREADY)
    else $error("error without ready");

  a_rdata_idle_zero: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !PREADY
    |-> PRDATA == 32'h0000_0000)
    else $error("read data outside answer");

  a_rdata_upper_zero: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    PREADY
    |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read data nonzero");

  a_write_rdata_zero: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && PWRITE)
    |=> PRDATA == 32'h0000_0000)
    else $error("read data on write");

  a_susp_read_back: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && !PWRITE && hit(PADDR, fet_pkg::OFS_SUSPEND_SEL))
    |=> PRDATA[15:0] == {15'h0000, $past(susp_reg)})
    else $error("suspend select read wrong");

  a_test_read_back: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && !PWRITE && hit(PADDR, fet_pkg::OFS_TEST_CTRL))
    |=> PRDATA[15:0] == {10'h000, $past(test_reg.code_verify_ecc_enable), $past(test_reg.data_verify_ecc_enable), 3'h0, $past(test_reg.encoder_disable_bit)})
    else $error("test control read wrong");

  a_mon_read_back: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && !PWRITE && hit(PADDR, fet_pkg::OFS_ENC_MON))
    |=> PRDATA[15:0] == $past(mon_reg))
    else $error("monitor read wrong");

  a_init_read_zero: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && !PWRITE && hit(PADDR, fet_pkg::OFS_INIT))
    |=> PRDATA == 32'h0000_0000)
    else $error("init register read nonzero");

  a_unmapped_error: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && !mapped(PADDR))
    |=> PSLVERR)
    else $error("unmapped access not refused");

  a_mapped_okay: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (setup && mapped(PADDR) && !(PWRITE && hit(PADDR, fet_pkg::OFS_ENC_MON)))
    |=> !PSLVERR)
    else $error("mapped access refused");

  a_susp_strobe_gate: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (PSEL && PENABLE && PREADY && PWRITE && PSTRB[1:0] != 2'h3)
    |=> $stable(susp_reg))
    else $error("narrow write changed suspend mode");

  a_test_strobe_gate: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (PSEL && PENABLE && PREADY && PWRITE && PSTRB[1:0] != 2'h3)
    |=> $stable(test_reg))
    else $error("narrow write changed test control");

  a_keyed_update: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_ok && hit(PADDR, fet_pkg::OFS_TEST_CTRL) && PWDATA[15:8] == fet_pkg::TEST_KEY)
    |=> test_reg == {$past(PWDATA[5]), $past(PWDATA[4]), $past(PWDATA[0])})
    else $error("keyed write not stored");

  a_susp_hold: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (!(wr_ok && hit(PADDR, fet_pkg::OFS_SUSPEND_SEL)) && !init_req)
    |=> $stable(susp_reg))
    else $error("suspend mode changed without write");

  a_test_hold: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !(wr_ok && hit(PADDR, fet_pkg::OFS_TEST_CTRL))
    |=> $stable(test_reg))
    else $error("test control changed without write");

  a_prio_follows: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    1'b1
    |=> ERASE_PRIORITY == $past(susp_reg))
    else $error("erase priority output stale");

  a_test_out_follows: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    1'b1
    |=> TEST_CTRL == $past(test_reg))
    else $error("test control output stale");

  a_code_ecc_live: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !DATA_FLASH_MODE
    |=> mon_reg[9:0] == $past(GEN_CODE.ecc))
    else $error("code ecc monitor wrong");

  a_code_parity_live: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !DATA_FLASH_MODE
    |=> mon_reg[10] == $past(GEN_CODE.parity))
    else $error("code parity monitor wrong");

  a_data_pad_ones: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    DATA_FLASH_MODE
    |=> mon_reg[9:7] == 3'h7)
    else $error("data ecc pad not one");

  a_bypass_data: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (test_reg.encoder_disable_bit && DATA_FLASH_MODE)
    |=> WRITE_CHECK[10:0] == {1'b1, 3'h7, $past(DUMMY_ECC[6:0])})
    else $error("data bypass value wrong");

  a_encode_code: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (!test_reg.encoder_disable_bit && !DATA_FLASH_MODE)
    |=> WRITE_CHECK[10:0] == $past(GEN_CODE))
    else $error("code encoder value not written");

  a_encode_data: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (!test_reg.encoder_disable_bit && DATA_FLASH_MODE)
    |=> WRITE_CHECK[10:0] == {1'b1, 3'h7, $past(GEN_DATA_ECC)})
    else $error("data encoder value not written");

  a_wcheck_upper_zero: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    1'b1
    |=> WRITE_CHECK[15:11] == 5'h00)
    else $error("write check upper bits set");

  a_init_only_bit: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (wr_ok && hit(PADDR, fet_pkg::OFS_INIT) && !PWDATA[fet_pkg::BIT_INIT])
    |=> $stable(susp_reg))
    else $error("init write of zero changed mode");

  // reserved monitor bits read zero once the first edge has loaded the register
  for (genvar i = 11; i < 16; i++) begin : g_mon_rsvd
    a_mon_rsvd_zero: assert property (
      @(posedge CORE_CLK) disable iff (!NRST)
      1'b1 |=> !mon_reg[i])
      else $error("reserved monitor bit set");
  end
endmodule // fet_ctrl

// ===== verification/test_fet_ctrl.sv
// self-checking bench for the flash ecc test and suspend-mode block
`timescale 1ns/1ps
module test_fet_ctrl;
  logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, dmode = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, erase_pri;
  fet_pkg::fet_code_t gen_code = '0;
  fet_pkg::fet_test_t tctrl;
  logic [6:0] gen_decc = 0;
  logic [15:0] dummy = 16'hFFFF, wcheck;
  int num_errors = 0, samples_checked = 0;
  always #25 core_clk = ~core_clk;
  fet_ctrl dut (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DATA_FLASH_MODE(dmode), .GEN_CODE(gen_code), .GEN_DATA_ECC(gen_decc), .DUMMY_ECC(dummy),
    .ERASE_PRIORITY(erase_pri), .TEST_CTRL(tctrl), .WRITE_CHECK(wcheck));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset();
    apb(0, 12'h0E0, 0); chk("suspend sel", 32'h0, q);
    apb(0, 12'h104, 0); chk("test ctrl", 32'h30, q);
    chk("test outputs", 3'b110, tctrl);
    $display("test reset done");
  endtask
  task automatic t_suspend();
    apb(1, 12'h0E0, 32'h1); settle(); chk("erase priority", 1, erase_pri);
    apb(0, 12'h0E0, 0); chk("suspend sel", 32'h1, q);
    apb(1, 12'h110, 32'h1); settle(); chk("erase priority", 0, erase_pri);
    apb(0, 12'h0E0, 0); chk("suspend sel", 32'h0, q);
    @(posedge core_clk);
    pstrb <= 4'h1;
    apb(1, 12'h0E0, 32'h1);
    pstrb <= 4'hF;
    apb(0, 12'h0E0, 0); chk("narrow write ignored", 32'h0, q);
    $display("test suspend done");
  endtask
  task automatic t_key();
    apb(1, 12'h104, 32'h0001); apb(0, 12'h104, 0); chk("no key", 32'h30, q);
    apb(1, 12'h104, 32'h5B01); apb(0, 12'h104, 0); chk("wrong key", 32'h30, q);
    apb(1, 12'h104, 32'hA601); apb(0, 12'h104, 0); chk("keyed", 32'h01, q);
    settle(); chk("test outputs", 3'b001, tctrl);
    apb(1, 12'h104, 32'hA620); settle(); chk("code ve only", 3'b100, tctrl);
    apb(1, 12'h104, 32'hA630); apb(0, 12'h104, 0); chk("restored", 32'h30, q);
    $display("test key done");
  endtask
  task automatic t_mon();
    @(posedge core_clk);
    gen_code <= {1'b1, 10'h2A5}; gen_decc <= 7'h55; dummy <= 16'hFC32;
    settle(); apb(0, 12'h100, 0); chk("code monitor", 32'h6A5, q);
    chk("code write", 11'h6A5, wcheck[10:0]);
    @(posedge core_clk);
    dmode <= 1'b1;
    settle(); apb(0, 12'h100, 0); chk("data monitor", 32'h7D5, q);
    apb(1, 12'h100, 32'h0); chk("monitor write err", 1, err);
    apb(0, 12'h100, 0); chk("monitor kept", 32'h7D5, q);
    apb(1, 12'h104, 32'hA631); settle(); chk("data bypass", 11'h7B2, wcheck[10:0]);
    @(posedge core_clk);
    dmode <= 1'b0;
    settle(); chk("code bypass", 11'h432, wcheck[10:0]);
    apb(0, 12'h200, 0); chk("unmapped err", 1, err);
    $display("test monitor done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    chk("reset test outputs", 3'b110, tctrl);
    chk("reset write check", 32'hFFFF, wcheck);
    chk("reset erase priority", 0, erase_pri);
    chk("reset read data", 0, prdata);
    nrst <= 1'b1;
    t_reset();
    t_suspend();
    t_key();
    t_mon();
    summarize();
  end
endmodule // test_fet_ctrl
